/* File: core/input_power_meter_config.sv */
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
// How it works
// - Accumulation length: 21 bits, split across registers.
// - Restart period low sixteen bits held separately.
// - Restart period high bits live in setup.
// - Nine-bit start offset after sync, eight-sample units.
// - Six-bit delay line offset; larger means longer.
// - Three-bit sync source select per delay line.
// - Meter b offset drives path b, c likewise.
// - Summing starts 8*offset+2 samples after sync.
// - After 8*length+1 samples, result readable, interrupt.
// - Period of 8*field+1 samples relaunches summing.
// - Square in-phase, add quadrature in complex mode.
module input_power_meter_config
   import meter_regs_pkg::*;
#(
   parameter int SW = SAMPLE_W,  // Sample width
   parameter int AW = ACC_W      // Accumulator width, above 32
) (
   input  wire logic              clock,
   input  wire logic              reset_n,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              sample_valid,
   input  wire logic              sync_pulse,
   input  wire logic              complex_mode,
   input  wire logic [SW-1:0]     in_phase_sample_b,
   input  wire logic [SW-1:0]     quadrature_sample_b,
   input  wire logic [SW-1:0]     in_phase_sample_c,
   input  wire logic [SW-1:0]     quadrature_sample_c,
   output logic [5:0]             delay_offset_b,
   output logic [5:0]             delay_offset_c,
   output logic [2:0]             sync_select_b,
   output logic [2:0]             sync_select_c,
   output logic                   irq
);
   logic [5:0]        idx;         // Word index of the access
   logic              cfg_meter;   // Meter c group when high
   logic              setup_phase; // First APB cycle
   logic              access;      // Second APB cycle
   logic              known;       // Address maps to a register
   logic              wr_en;       // Write takes effect now
   logic [31:0]       rd_word;     // Read mux output
   logic [31:0]       prdata_reg;  // Read data launched in setup
   logic [METERS-1:0] status_reg;  // Sticky completion bits
   logic [METERS-1:0] status_next;
   logic [METERS-1:0] mask_reg;    // Interrupt enables
   logic              irq_reg;     // Registered interrupt level

   wire [15:0]        cfg_rd [METERS];   // Per-meter read word
   wire [AW-1:0]      power_w [METERS];  // Per-meter result
   wire [METERS-1:0]  done_w;            // Per-meter completion
   wire [5:0]         line_ofs [METERS]; // Delay line offsets
   wire [2:0]         sync_sel [METERS]; // Sync source selects
   wire [SW-1:0]      ip_w [METERS];     // In-phase per meter
   wire [SW-1:0]      qd_w [METERS];     // Quadrature per meter

   // Meter configuration words sit at indices 0x0c to 0x13
   function automatic logic is_cfg(input logic [5:0] i);
      is_cfg = i >= IDX_B_ACCUM_LOW && i <= IDX_C_SETUP;
   endfunction

   // Any mapped, word-aligned register
   function automatic logic is_known(input logic [5:0] i,
                                     input logic [1:0] lo);
      is_known = lo == 2'h0 &&
                 (is_cfg(i) ||
                  (i >= IDX_IRQ_STATUS && i <= IDX_C_POWER_HIGH));
   endfunction

   assign idx         = paddr[ADDR_W-1:2];
   assign cfg_meter   = idx >= IDX_C_ACCUM_LOW;
   assign setup_phase = psel && !penable;
   assign access      = psel && penable;
   assign known       = is_known(idx, paddr[1:0]);
   assign wr_en       = access && pwrite && known;

   // Zero wait states; unmapped or misaligned addresses error out
   assign pready  = 1'b1;
   assign pslverr = access && !known;
   assign prdata  = prdata_reg;

   assign ip_w[0] = in_phase_sample_b;
   assign qd_w[0] = quadrature_sample_b;
   assign ip_w[1] = in_phase_sample_c;
   assign qd_w[1] = quadrature_sample_c;

   // One register group, link and engine per meter
   for (genvar m = 0; m < METERS; m++) begin : g_meter
      logic [15:0] accum_low_reg;   // Length bits 15:0
      logic [15:0] restart_low_reg; // Period bits 15:0
      logic [15:0] offset_reg;      // Line offset and start delay
      logic [15:0] setup_reg;       // High bits and sync select
      logic        sel;             // Write aimed at this meter

      assign sel = wr_en && is_cfg(idx) && cfg_meter == 1'(m);

      // Register writes; unused bits are never stored
      always_ff @(posedge clock or negedge reset_n) begin
         if (!reset_n) begin
            accum_low_reg   <= REG_RESET;
            restart_low_reg <= REG_RESET;
            offset_reg      <= REG_RESET;
            setup_reg       <= REG_RESET;
         end else if (sel) begin
            case (idx[1:0])
               SLOT_ACCUM: begin
                  accum_low_reg <= pwdata[15:0];
               end
               SLOT_RESTART: begin
                  restart_low_reg <= pwdata[15:0];
               end
               SLOT_OFFSET: begin
                  offset_reg <= pwdata[15:0] & OFFSET_WR_MASK;
               end
               SLOT_SETUP: begin
                  setup_reg <= pwdata[15:0] & SETUP_WR_MASK;
               end
               default: begin
                  setup_reg <= setup_reg;
               end
            endcase
         end
      end

      // Read back the stored word of the addressed slot
      assign cfg_rd[m] = idx[1:0] == SLOT_ACCUM   ? accum_low_reg   :
                         idx[1:0] == SLOT_RESTART ? restart_low_reg :
                         idx[1:0] == SLOT_OFFSET  ? offset_reg      :
                                                    setup_reg;

      meter_link_if #(.AW(AW)) link ();

      // Length: five high bits from setup above the low word
      assign link.accum_length = {setup_reg[ACC_HI_LSB +: 5],
                                  accum_low_reg};
      // Period: 20:18 in the upper byte, 17:16 in the lower
      assign link.restart_period = {setup_reg[RST_TOP_LSB +: 3],
                                    setup_reg[RST_MID_LSB +: 2],
                                    restart_low_reg};
      assign link.start_offset = offset_reg[8:0];
      assign line_ofs[m] = offset_reg[LINE_LSB +: 6];
      assign sync_sel[m] = setup_reg[2:0];
      assign power_w[m]  = link.power;
      assign done_w[m]   = link.done;

      meter_engine #(
         .SW (SW),
         .AW (AW)
      ) u_engine (
         .clock             (clock),
         .reset_n           (reset_n),
         .sample_valid      (sample_valid),
         .sync_pulse        (sync_pulse),
         .complex_mode      (complex_mode),
         .in_phase_sample   (ip_w[m]),
         .quadrature_sample (qd_w[m]),
         .link              (link.engine)
      );
   end

   // Each meter feeds its own receive path
   assign delay_offset_b = line_ofs[0];
   assign delay_offset_c = line_ofs[1];
   assign sync_select_b  = sync_sel[0];
   assign sync_select_c  = sync_sel[1];

   // Read mux; narrow words sit low, everything above reads zero
   always_comb begin
      rd_word = '0;
      if (!known) begin
         rd_word = '0;
      end else if (is_cfg(idx)) begin
         rd_word = 32'(cfg_rd[cfg_meter]);
      end else begin
         case (idx)
            IDX_IRQ_STATUS: begin
               rd_word = 32'(status_reg);
            end
            IDX_IRQ_MASK: begin
               rd_word = 32'(mask_reg);
            end
            IDX_B_POWER_LOW: begin
               rd_word = power_w[0][31:0];
            end
            IDX_B_POWER_HIGH: begin
               rd_word = 32'(power_w[0][AW-1:32]);
            end
            IDX_C_POWER_LOW: begin
               rd_word = power_w[1][31:0];
            end
            IDX_C_POWER_HIGH: begin
               rd_word = 32'(power_w[1][AW-1:32]);
            end
            default: begin
               rd_word = '0;
            end
         endcase
      end
   end

   // Read data launched in setup so it stands through the access
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         prdata_reg <= '0;
      end else if (setup_phase && !pwrite) begin
         prdata_reg <= rd_word;
      end
   end

   // Write-one-to-clear, but a new completion beats the clear
   always_comb begin
      status_next = status_reg;
      if (wr_en && idx == IDX_IRQ_STATUS) begin
         status_next = status_reg & ~pwdata[METERS-1:0];
      end
      status_next = status_next | done_w;
   end

   // Sticky completion status
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         status_reg <= '0;
      end else begin
         status_reg <= status_next;
      end
   end

   // Interrupt mask
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mask_reg <= '0;
      end else if (wr_en && idx == IDX_IRQ_MASK) begin
         mask_reg <= pwdata[METERS-1:0];
      end
   end

   // Level interrupt, one cycle behind status to stay glitch free
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(status_reg & mask_reg);
      end
   end

   assign irq = irq_reg;

   sequence wr_s(logic [5:0] target);
      access && pwrite && paddr == {target, 2'h0};
   endsequence

   accum_low_store_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      wr_s(IDX_B_ACCUM_LOW) |=>
         g_meter[0].link.accum_length[15:0] == $past(pwdata[15:0]))
      else $error("Length low word not stored");

   restart_low_store_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      wr_s(IDX_C_RESTART_LOW) |=>
         g_meter[1].link.restart_period[15:0] == $past(pwdata[15:0]))
      else $error("Period low word not stored");

   restart_high_split_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      wr_s(IDX_B_SETUP) |=>
         g_meter[0].link.restart_period[20:16] ==
            {$past(pwdata[10:8]), $past(pwdata[7:6])} &&
         g_meter[0].link.accum_length[20:16] == $past(pwdata[15:11]))
      else $error("Setup high bits misplaced");

   start_offset_store_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      wr_s(IDX_C_START_OFS) |=>
         g_meter[1].link.start_offset == $past(pwdata[8:0]))
      else $error("Start offset not stored");

   line_to_path_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      wr_s(IDX_B_START_OFS) |=>
         delay_offset_b == $past(pwdata[15:10]) && $stable(delay_offset_c))
      else $error("Delay offset reached wrong path");

   sync_select_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      wr_s(IDX_C_SETUP) |=> sync_select_c == $past(pwdata[2:0]))
      else $error("Sync select not stored");

   unused_read_zero_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      (setup_phase && !pwrite && idx == IDX_B_SETUP) |=>
         prdata[5:3] == 3'h0 && prdata[31:16] == 16'h0000)
      else $error("Unused bits read nonzero");

   // A mask write in the done cycle may legally hide the line
   done_sets_irq_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      (done_w[0] && mask_reg[0] && !(wr_en && idx == IDX_IRQ_MASK))
      |=> status_reg[0] ##1 irq)
      else $error("Completion did not raise interrupt");

   // A cleared flag stays clear when no completion collides
   status_clear_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      (wr_en && idx == IDX_IRQ_STATUS && pwdata[0] && !done_w[0])
      |=> !status_reg[0])
      else $error("Status bit not cleared");

   // Set beats a clear landing in the same cycle
   status_set_wins_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      done_w[0] |=> status_reg[0])
      else $error("Completion lost to clear");

   // Masked status must keep the line low
   mask_blocks_irq_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      !(|(status_reg & mask_reg)) |=> !irq)
      else $error("Interrupt raised while masked");

   // Refused write leaves the bank untouched
   bad_write_kept_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      (access && pwrite && !known) |=>
         $stable(g_meter[0].link.accum_length) && $stable(mask_reg))
      else $error("Refused write changed state");

   // Refused read returns an all-zero word
   bad_read_zero_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      (setup_phase && !pwrite && !known) |=> prdata == 32'h0)
      else $error("Refused read returned data");

   // Finished energy shows on the low power word read
   power_read_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      (setup_phase && !pwrite && idx == IDX_B_POWER_LOW && known) |=>
         prdata == $past(power_w[0][31:0]))
      else $error("Power word not readable");
endmodule

/* File: core/meter_regs_pkg.sv */
// Shared constants for the receive power meter configuration bank
package meter_regs_pkg;
   localparam int METERS   = 2;   // Meters b and c
   localparam int SAMPLE_W = 16;  // Receive sample width
   localparam int ACC_W    = 48;  // Energy accumulator width
   localparam int COUNT_W  = 24;  // Sample counters, hold 8*(2^21-1)+1
   localparam int LEN_W    = 21;  // Length and period fields
   localparam int ADDR_W   = 8;   // APB byte address width
   localparam int UNIT_SHIFT = 3; // Eight samples per count unit

   // Fixed sample tails added to the eight-sample products
   localparam logic [1:0] START_EXTRA  = 2'h2;
   localparam logic [1:0] ACCUM_EXTRA  = 2'h1;
   localparam logic [1:0] PERIOD_EXTRA = 2'h1;

   // Word indices; the byte address is four times the index
   localparam logic [5:0] IDX_B_ACCUM_LOW   = 6'h0c;
   localparam logic [5:0] IDX_B_RESTART_LOW = 6'h0d;
   localparam logic [5:0] IDX_B_START_OFS   = 6'h0e;
   localparam logic [5:0] IDX_B_SETUP       = 6'h0f;
   localparam logic [5:0] IDX_C_ACCUM_LOW   = 6'h10;
   localparam logic [5:0] IDX_C_RESTART_LOW = 6'h11;
   localparam logic [5:0] IDX_C_START_OFS   = 6'h12;
   localparam logic [5:0] IDX_C_SETUP       = 6'h13;
   localparam logic [5:0] IDX_IRQ_STATUS    = 6'h18;
   localparam logic [5:0] IDX_IRQ_MASK      = 6'h19;
   localparam logic [5:0] IDX_B_POWER_LOW   = 6'h1a;
   localparam logic [5:0] IDX_B_POWER_HIGH  = 6'h1b;
   localparam logic [5:0] IDX_C_POWER_LOW   = 6'h1c;
   localparam logic [5:0] IDX_C_POWER_HIGH  = 6'h1d;

   // Low two index bits pick the word within one meter group
   localparam logic [1:0] SLOT_ACCUM   = 2'h0;
   localparam logic [1:0] SLOT_RESTART = 2'h1;
   localparam logic [1:0] SLOT_OFFSET  = 2'h2;
   localparam logic [1:0] SLOT_SETUP   = 2'h3;

   // Field positions
   localparam int LINE_LSB     = 10; // Delay line offset 15:10
   localparam int ACC_HI_LSB   = 11; // Length bits 20:16 at 15:11
   localparam int RST_TOP_LSB  = 8;  // Period bits 20:18 at 10:8
   localparam int RST_MID_LSB  = 6;  // Period bits 17:16 at 7:6

   // Writable bits; the rest are unused and read zero
   localparam logic [15:0] OFFSET_WR_MASK = 16'hfdff;
   localparam logic [15:0] SETUP_WR_MASK  = 16'hffc7;
   localparam logic [15:0] REG_RESET      = 16'h0000;
endpackage

/* File: core/meter_link_if.sv */
`timescale 1ns/10ps
// Settings into one meter engine, result back out
interface meter_link_if
   import meter_regs_pkg::*;
#(
   parameter int AW = ACC_W
);
   logic [LEN_W-1:0] accum_length;   // Length, eight-sample units
   logic [LEN_W-1:0] restart_period; // Period, eight-sample units
   logic [8:0]       start_offset;   // Delay from sync
   logic [AW-1:0]    power;          // Last finished sum
   logic             done;           // One-cycle completion pulse

   modport engine (input accum_length, restart_period, start_offset,
                   output power, done);
   modport bank   (output accum_length, restart_period, start_offset,
                   input power, done);
endinterface

/* File: core/meter_engine.sv */
`timescale 1ns/10ps
// One meter: waits out the start offset after sync, then squares and
// sums samples; a restart-period counter relaunches the sum.
module meter_engine
   import meter_regs_pkg::*;
#(
   parameter int SW = SAMPLE_W,  // Sample width
   parameter int AW = ACC_W      // Accumulator width
) (
   input  wire logic          clock,
   input  wire logic          reset_n,
   input  wire logic          sample_valid,
   input  wire logic          sync_pulse,
   input  wire logic          complex_mode,
   input  wire logic [SW-1:0] in_phase_sample,
   input  wire logic [SW-1:0] quadrature_sample,
   meter_link_if.engine       link
);
   typedef enum logic [1:0] {IDLE, DELAY, ACCUM, HOLD} phase_type;

   phase_type          phase_reg;     // Sequencer state
   logic [COUNT_W-1:0] delay_cnt_reg; // Samples since sync
   logic [COUNT_W-1:0] acc_cnt_reg;   // Samples summed so far
   logic [COUNT_W-1:0] per_cnt_reg;   // Samples into the period
   logic [AW-1:0]      acc_reg;       // Running energy
   logic [AW-1:0]      power_reg;     // Finished energy
   logic               done_reg;      // Completion pulse
   logic [AW-1:0]      sq_sum;        // This sample's energy
   logic [COUNT_W-1:0] start_target;
   logic [COUNT_W-1:0] accum_target;
   logic [COUNT_W-1:0] period_target;
   logic               start_due;
   logic               accum_due;
   logic               restart_due;

   // Units of eight samples plus a fixed tail
   function automatic logic [COUNT_W-1:0] to_samples(
      input logic [LEN_W-1:0] units, input logic [1:0] extra);
      to_samples = (COUNT_W'(units) << UNIT_SHIFT) + COUNT_W'(extra);
   endfunction

   // Square of a signed sample, widened to the accumulator
   function automatic logic [AW-1:0] square(input logic [SW-1:0] s);
      logic signed [2*SW-1:0] p;
      p = $signed(s) * $signed(s);
      square = AW'(p);
   endfunction

   assign start_target  = to_samples(LEN_W'(link.start_offset),
                                     START_EXTRA);
   assign accum_target  = to_samples(link.accum_length,
                                     ACCUM_EXTRA);
   assign period_target = to_samples(link.restart_period,
                                     PERIOD_EXTRA);

   // Quadrature energy only counts in complex mode
   always_comb begin
      sq_sum = square(in_phase_sample) +
               (complex_mode ? square(quadrature_sample) : '0);
   end

   // Sync always wins, so a fresh sync re-aligns a running meter
   assign start_due   = !sync_pulse && sample_valid && phase_reg == DELAY
                        && delay_cnt_reg + COUNT_W'(1) == start_target;
   assign accum_due   = !sync_pulse && sample_valid && phase_reg == ACCUM
                        && acc_cnt_reg + COUNT_W'(1) == accum_target;
   assign restart_due = !sync_pulse && sample_valid &&
                        (phase_reg == ACCUM || phase_reg == HOLD) &&
                        per_cnt_reg + COUNT_W'(1) == period_target;

   // Sequencer and sample counters
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         phase_reg     <= IDLE;
         delay_cnt_reg <= '0;
         acc_cnt_reg   <= '0;
         per_cnt_reg   <= '0;
      end else if (sync_pulse) begin
         phase_reg     <= DELAY;
         delay_cnt_reg <= '0;
      end else if (sample_valid) begin
         case (phase_reg)
            DELAY: begin
               delay_cnt_reg <= delay_cnt_reg + COUNT_W'(1);
               if (start_due) begin
                  phase_reg   <= ACCUM;
                  acc_cnt_reg <= '0;
                  per_cnt_reg <= '0;
               end
            end
            ACCUM, HOLD: begin
               per_cnt_reg <= per_cnt_reg + COUNT_W'(1);
               if (restart_due) begin
                  phase_reg   <= ACCUM;
                  acc_cnt_reg <= '0;
                  per_cnt_reg <= '0;
               end else if (accum_due) begin
                  phase_reg <= HOLD;
               end else if (phase_reg == ACCUM) begin
                  acc_cnt_reg <= acc_cnt_reg + COUNT_W'(1);
               end
            end
            default: begin
               phase_reg <= IDLE;
            end
         endcase
      end
   end

   // Energy accumulator, emptied at every launch
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         acc_reg <= '0;
      end else if (sync_pulse || start_due || restart_due) begin
         acc_reg <= '0;
      end else if (sample_valid && phase_reg == ACCUM) begin
         acc_reg <= acc_reg + sq_sum;
      end
   end

   // Result capture with one-cycle completion pulse
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         power_reg <= '0;
         done_reg  <= 1'b0;
      end else begin
         done_reg <= accum_due;
         if (accum_due) begin
            power_reg <= acc_reg + sq_sum;
         end
      end
   end

   assign link.power = power_reg;
   assign link.done  = done_reg;

   sequence last_sample_s;
      accum_due;
   endsequence

   done_on_last_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      last_sample_s |=> link.done ##1 !link.done)
      else $error("Completion pulse missing or too long");

   start_after_delay_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      start_due |=> phase_reg == ACCUM && acc_reg == '0 &&
                    acc_cnt_reg == '0)
      else $error("Summing did not start after sync delay");

   restart_clears_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      restart_due |=> phase_reg == ACCUM && per_cnt_reg == '0)
      else $error("Restart period did not relaunch summing");

   energy_adds_a: assert property (
      @(posedge clock) disable iff (!reset_n)
      (sample_valid && phase_reg == ACCUM && !sync_pulse && !restart_due)
      |=> acc_reg == $past(acc_reg) + $past(sq_sum))
      else $error("Sample energy not added");
endmodule

/* File: sim/input_power_meter_config_tb.sv */
`timescale 1ns/10ps
module input_power_meter_config_tb;
   import meter_regs_pkg::*;
   logic        clock = 1'b0;    // 20 MHz
   logic        reset_n = 1'b0;  // Async, active low
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd_data;
   logic        pready, pslverr, rd_err, irq;
   logic        sample_valid = 1'b1, sync_pulse = 1'b0, complex_mode = 1'b0;
   logic [15:0] i_b = 16'h0002, q_b = 16'h0001, i_c = 16'h0003, q_c = 16'h0;
   logic [5:0]  delay_offset_b, delay_offset_c, base;
   logic [2:0]  sync_select_b, sync_select_c;
   int          errors = 0, num_checks = 0, cycles = 0, lat [2];
   input_power_meter_config dut (.clock(clock), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_valid(sample_valid), .sync_pulse(sync_pulse),
      .complex_mode(complex_mode), .in_phase_sample_b(i_b),
      .quadrature_sample_b(q_b), .in_phase_sample_c(i_c),
      .quadrature_sample_c(q_c), .delay_offset_b(delay_offset_b),
      .delay_offset_c(delay_offset_c), .sync_select_b(sync_select_b),
      .sync_select_c(sync_select_c), .irq(irq));
   // Clock and hang guard
   always #25 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         stop_test();
      end
   end
   // Compare one value
   task automatic check(input string name, input logic [31:0] exp,
                        input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   // One APB transfer; holds all until pready seen at an edge
   task automatic apb(input logic wr, input logic [5:0] idx,
                      input logic [15:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {16'h0, d};
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Read one word and compare all of it, upper half expected zero
   task automatic rd(input logic [5:0] idx, input logic [15:0] exp);
      apb(1'b0, idx, 16'h0);
      check($sformatf("reg %h", idx), {16'h0, exp}, rd_data);
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clock);
      reset_n <= 1'b1;
      // Reset values, field widths and unused bits for both meters
      for (int m = 0; m < 2; m++) begin
         base = m ? IDX_C_ACCUM_LOW : IDX_B_ACCUM_LOW;
         for (int r = 0; r < 4; r++) rd(6'(base + r), 16'h0000);
         for (int r = 0; r < 4; r++) apb(1'b1, 6'(base + r), 16'hffff);
         rd(base, 16'hffff);
         rd(6'(base + 1), 16'hffff);
         rd(6'(base + 2), 16'hfdff);
         rd(6'(base + 3), 16'hffc7);
      end
      check("delay b", 32'h3f, {26'h0, delay_offset_b});
      check("delay c", 32'h3f, {26'h0, delay_offset_c});
      check("ssel b", 32'h7, {29'h0, sync_select_b});
      check("ssel c", 32'h7, {29'h0, sync_select_c});
      apb(1'b1, IDX_B_START_OFS, 16'h0400);
      @(posedge clock);
      check("delay b", 32'h01, {26'h0, delay_offset_b});
      rd(6'h20, 16'h0000);
      check("slverr", 32'h1, {31'h0, rd_err});
      apb(1'b1, 6'h20, 16'hffff);
      check("slverr wr", 32'h1, {31'h0, rd_err});
      // Meter b: length 1 unit, period 16 units
      apb(1'b1, IDX_B_ACCUM_LOW, 16'h0001);
      apb(1'b1, IDX_B_RESTART_LOW, 16'h0010);
      apb(1'b1, IDX_B_SETUP, 16'h0000);
      apb(1'b1, IDX_IRQ_MASK, 16'h0001);
      // Offset 0 real, then offset 1 complex; latency differs by 8
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, IDX_B_START_OFS, k[15:0]);
         apb(1'b1, IDX_IRQ_STATUS, 16'h0003);
         complex_mode <= k[0];
         @(posedge clock) sync_pulse <= 1'b1;
         @(posedge clock) sync_pulse <= 1'b0;
         lat[k] = 0;
         while (irq !== 1'b1 && lat[k] < 300) begin
            @(posedge clock);
            lat[k]++;
         end
         rd(IDX_B_POWER_LOW, k ? 16'd45 : 16'd36);
         rd(IDX_IRQ_STATUS, 16'h0001);
      end
      check("latency", 32'd8, lat[1] - lat[0]);
      // Mask hides, status stays, write one clears
      apb(1'b1, IDX_IRQ_MASK, 16'h0000);
      repeat (3) @(posedge clock);
      check("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, IDX_IRQ_MASK, 16'h0001);
      repeat (3) @(posedge clock);
      check("irq unmasked", 32'h1, {31'h0, irq});
      apb(1'b1, IDX_IRQ_STATUS, 16'h0001);
      repeat (3) @(posedge clock);
      check("irq cleared", 32'h0, {31'h0, irq});
      // Period boundary relaunches without a new sync
      lat[0] = 0;
      while (irq !== 1'b1 && lat[0] < 300) begin
         @(posedge clock);
         lat[0]++;
      end
      check("restart irq", 32'h1, {31'h0, irq});
      stop_test();
   end
endmodule
